/* hw/alarm_cfg.svh */
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH

// Internal register addresses
`define ADDR_WEEKDAY 4'h3
`define ADDR_WEEKLY_MINUTE 4'h8
`define ADDR_WEEKLY_HOUR 4'h9
`define ADDR_WEEKLY_DAY_MASK 4'ha
`define ADDR_DAILY_MINUTE 4'hb
`define ADDR_DAILY_HOUR 4'hc

// Field positions
`define HOUR_PM_BIT 5
`define MINUTE_MSB 6
`define HOUR_MSB 5
`define DAY_MASK_MSB 6
`define WEEKDAY_MSB 2

// Reset values and counter limits
`define ALARM_RESET_VALUE 8'h00
`define WEEKDAY_RESET 3'h0
`define WEEKDAY_LAST 3'h6

`endif

/* hw/alarm_pkg.sv */
package alarm_pkg;
  typedef logic [6:0] bcd_minute_t;
  typedef logic [5:0] bcd_hour_t;
  typedef logic [6:0] day_mask_t;
  typedef logic [2:0] weekday_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
endpackage

/* hw/alarm_match_if.sv */
`timescale 1ns/100ps
interface alarm_match_if;
  import alarm_pkg::*;
  bcd_minute_t cur_minute;
  bcd_hour_t cur_hour;
  bcd_minute_t alarm_minute;
  bcd_hour_t alarm_hour;
  logic day_ok;
  logic hit;
  modport owner(output cur_minute, output cur_hour, output alarm_minute,
                output alarm_hour, output day_ok, input hit);
  modport cmp(input cur_minute, input cur_hour, input alarm_minute,
              input alarm_hour, input day_ok, output hit);
endinterface

/* hw/alarm_comparator.sv */
`timescale 1ns/100ps
module alarm_comparator (
  alarm_match_if.cmp port
);
  import alarm_pkg::*;
  // Raw code compare, so 12-hour codes (12 midnight, 32 noon) match as is
  always_comb begin
    port.hit = (port.cur_minute == port.alarm_minute) &&
               (port.cur_hour == port.alarm_hour) && port.day_ok; // [RQ3]
  end
endmodule // alarm_comparator

/* hw/alarm_regs.sv */
`timescale 1ns/100ps
`include "alarm_cfg.svh"
// Overview of operation
// RQ1: In 12-hour mode weekly hour bit 5 is the afternoon flag, in 24-hour mode the tens-two bit.
// RQ2: Daily hour bit 5 is the tens-two bit in 24-hour mode and the afternoon flag in 12-hour mode.
// RQ3: In 12-hour mode midnight is coded 12 and noon 32, the same coding as the current time.
// RQ4: Day-enable bit n of the weekly alarm belongs to day counter value n, codes 0 to 6.
// RQ5: With all seven day-enable bits clear the weekly alarm never matches.
// RQ6: Weekly hour at 9h keeps six bits, bits 7 and 6 ignore writes and read zero.
// RQ7: Weekly day mask at Ah keeps seven bits, bit 7 ignores writes and reads zero.
// RQ8: Daily minute at Bh keeps a seven-bit BCD minute, bit 7 reads zero.
// RQ9: Daily hour at Ch keeps six bits, bits 7 and 6 ignore writes and read zero.
// RQ10: After an oscillator stop the alarm values are undefined while unused bits read zero.
// RQ11: Software programs only valid alarm times, else the alarm may never match.
// RQ12: Software maps weekdays to day-enable bits to suit its own day coding.
// RQ13: Weekly minute at 8h keeps a seven-bit BCD minute, bit 7 reads zero.
// RQ14: The day counter counts 0 to 6 and wraps to 0, and selects the day-enable bit.
// RQ15: The weekly alarm matches on equal minute and hour when the current day bit is set.
// RQ16: The daily alarm matches every day on equal minute and hour.
module alarm_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire alarm_pkg::reg_addr_t reg_addr,
  input wire alarm_pkg::reg_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output alarm_pkg::reg_data_t reg_rdata,
  input wire alarm_pkg::bcd_minute_t cur_minute,
  input wire alarm_pkg::bcd_hour_t cur_hour,
  input wire logic mode_24h,
  input wire logic day_carry,
  input wire logic osc_stop_flag,
  output alarm_pkg::weekday_t weekday,
  output logic weekly_match,
  output logic daily_match,
  output logic weekly_pm,
  output logic daily_pm_flag
);
  import alarm_pkg::*;

  bcd_minute_t weekly_minute;
  bcd_hour_t weekly_hour;
  day_mask_t weekly_day_mask;
  bcd_minute_t daily_minute;
  bcd_hour_t daily_hour;
  weekday_t next_weekday;
  reg_data_t next_rdata;

  alarm_match_if weekly_if();
  alarm_match_if daily_if();

  // Write strobe decode shared by every register
  function automatic logic wr_hit(input reg_addr_t a, input reg_addr_t target);
    wr_hit = (a == target);
  endfunction

  // Bit 5 is a meridiem flag only while 12-hour mode is selected
  function automatic logic pm_of(input bcd_hour_t h, input logic m24);
    pm_of = !m24 && h[`HOUR_PM_BIT];
  endfunction

  // Weekly alarm storage; upper bits are not stored so they cannot stick
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      weekly_minute <= bcd_minute_t'(`ALARM_RESET_VALUE);
      weekly_hour <= bcd_hour_t'(`ALARM_RESET_VALUE);
      weekly_day_mask <= day_mask_t'(`ALARM_RESET_VALUE);
    end else if (reg_wr) begin
      if (wr_hit(reg_addr, `ADDR_WEEKLY_MINUTE)) begin
        weekly_minute <= reg_wdata[`MINUTE_MSB:0]; // [RQ13]
      end
      if (wr_hit(reg_addr, `ADDR_WEEKLY_HOUR)) begin
        weekly_hour <= reg_wdata[`HOUR_MSB:0]; // [RQ6]
      end
      if (wr_hit(reg_addr, `ADDR_WEEKLY_DAY_MASK)) begin
        weekly_day_mask <= reg_wdata[`DAY_MASK_MSB:0]; // [RQ7]
      end
    end
  end

  // Daily alarm storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      daily_minute <= bcd_minute_t'(`ALARM_RESET_VALUE);
      daily_hour <= bcd_hour_t'(`ALARM_RESET_VALUE);
    end else if (reg_wr) begin
      if (wr_hit(reg_addr, `ADDR_DAILY_MINUTE)) begin
        daily_minute <= reg_wdata[`MINUTE_MSB:0]; // [RQ8]
      end
      if (wr_hit(reg_addr, `ADDR_DAILY_HOUR)) begin
        daily_hour <= reg_wdata[`HOUR_MSB:0]; // [RQ9]
      end
    end
  end

  // Day counter: a write wins over a carry in the same cycle
  always_comb begin
    next_weekday = weekday;
    if (reg_wr && wr_hit(reg_addr, `ADDR_WEEKDAY)) begin
      next_weekday = reg_wdata[`WEEKDAY_MSB:0];
    end else if (day_carry) begin
      // A prohibited code 7 also falls back to 0 rather than lock up
      if (weekday >= `WEEKDAY_LAST) begin
        next_weekday = `WEEKDAY_RESET; // [RQ14]
      end else begin
        next_weekday = weekday + 3'h1; // [RQ14]
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      weekday <= `WEEKDAY_RESET;
    end else begin
      weekday <= next_weekday;
    end
  end

  // Read mux; unmapped addresses and unused bits give zero
  always_comb begin
    case (reg_addr)
      `ADDR_WEEKDAY: next_rdata = {5'h00, weekday};
      `ADDR_WEEKLY_MINUTE: next_rdata = {1'h0, weekly_minute}; // [RQ13]
      `ADDR_WEEKLY_HOUR: next_rdata = {2'h0, weekly_hour}; // [RQ6]
      `ADDR_WEEKLY_DAY_MASK: next_rdata = {1'h0, weekly_day_mask}; // [RQ7]
      `ADDR_DAILY_MINUTE: next_rdata = {1'h0, daily_minute}; // [RQ8]
      `ADDR_DAILY_HOUR: next_rdata = {2'h0, daily_hour}; // [RQ9]
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data held until the next read strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00; // [RQ10]
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Hand the current time and stored alarm to each comparator
  assign weekly_if.cur_minute = cur_minute;
  assign weekly_if.cur_hour = cur_hour;
  assign weekly_if.alarm_minute = weekly_minute;
  assign weekly_if.alarm_hour = weekly_hour;
  // Prohibited code 7 selects no day bit instead of an unknown one
  assign weekly_if.day_ok = (weekday <= `WEEKDAY_LAST) && weekly_day_mask[weekday]; // [RQ4] [RQ5]
  assign daily_if.cur_minute = cur_minute;
  assign daily_if.cur_hour = cur_hour;
  assign daily_if.alarm_minute = daily_minute;
  assign daily_if.alarm_hour = daily_hour;
  assign daily_if.day_ok = 1'b1; // [RQ16]

  alarm_comparator weekly_cmp (
    .port(weekly_if.cmp)
  );

  alarm_comparator daily_cmp (
    .port(daily_if.cmp)
  );

  // Match levels registered; held off while the oscillator is flagged stopped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      weekly_match <= 1'b0;
      daily_match <= 1'b0;
    end else begin
      weekly_match <= weekly_if.hit && !osc_stop_flag; // [RQ15] [RQ10]
      daily_match <= daily_if.hit && !osc_stop_flag; // [RQ16] [RQ10]
    end
  end

  // Meridiem view of bit 5, zero in 24-hour mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      weekly_pm <= 1'b0;
      daily_pm_flag <= 1'b0;
    end else begin
      weekly_pm <= pm_of(weekly_hour, mode_24h); // [RQ1]
      daily_pm_flag <= pm_of(daily_hour, mode_24h); // [RQ2]
    end
  end

  // Checks
  sequence read_of(reg_addr_t a);
    reg_rd && reg_addr == a;
  endsequence

  sequence write_of(reg_addr_t a);
    reg_wr && reg_addr == a;
  endsequence

  week_hour_upper_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ6]
    read_of(`ADDR_WEEKLY_HOUR) |=> reg_rdata[7:6] == 2'h0)
    else $error("weekly hour upper bits not zero");

  day_mask_top_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
    write_of(`ADDR_WEEKLY_DAY_MASK) ##1 read_of(`ADDR_WEEKLY_DAY_MASK)
    |=> reg_rdata == {1'b0, $past(reg_wdata[6:0], 2)})
    else $error("day mask readback wrong");

  daily_min_top_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ8]
    read_of(`ADDR_DAILY_MINUTE) |=> !reg_rdata[7])
    else $error("daily minute bit 7 set");

  daily_hour_upper_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ9]
    write_of(`ADDR_DAILY_HOUR) ##1 read_of(`ADDR_DAILY_HOUR)
    |=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)})
    else $error("daily hour readback wrong");

  week_min_top_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ13]
    read_of(`ADDR_WEEKLY_MINUTE) |=> reg_rdata[7] == 1'b0)
    else $error("weekly minute bit 7 set");

  weekday_wrap_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ14]
    day_carry && !reg_wr && weekday == 3'h6 |=> weekday == 3'h0)
    else $error("day counter did not wrap");

  weekday_step_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ14]
    day_carry && !reg_wr && weekday < 3'h6 |=> weekday == $past(weekday) + 3'h1)
    else $error("day counter did not step");

  empty_mask_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ5]
    weekly_day_mask == 7'h00 |=> !weekly_match)
    else $error("weekly match with empty mask");

  weekly_hit_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ15]
    1'b1 |=> weekly_match == ($past(cur_minute) == $past(weekly_minute) &&
      $past(cur_hour) == $past(weekly_hour) &&
      $past(weekday <= 3'h6 && weekly_day_mask[weekday]) && !$past(osc_stop_flag)))
    else $error("weekly match wrong");

  daily_hit_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ16]
    cur_minute == daily_minute && cur_hour == daily_hour && !osc_stop_flag
    |=> daily_match)
    else $error("daily match missed");

  meridiem_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ1]
    mode_24h |=> !weekly_pm && !daily_pm_flag)
    else $error("meridiem flag set in 24-hour mode");

  daily_pm_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ2]
    !mode_24h && daily_hour[5] |=> daily_pm_flag)
    else $error("daily afternoon flag missing");
endmodule // alarm_regs

/* tb/time_source.sv */
`timescale 1ns/100ps
module time_source (
  input wire logic core_clk,
  output alarm_pkg::bcd_minute_t cur_minute,
  output alarm_pkg::bcd_hour_t cur_hour,
  output logic mode_24h,
  output logic day_carry
);
  import alarm_pkg::*;

  // Idle time source at midnight in 12-hour coding until told otherwise
  initial begin
    cur_minute = 7'h00;
    cur_hour = 6'h12;
    mode_24h = 1'b0;
    day_carry = 1'b0;
  end

  // Only existing times are loaded, 12/32 coding in 12-hour mode
  task set_time(input bcd_minute_t m, input bcd_hour_t h, input logic m24);
    @(posedge core_clk);
    #1;
    cur_minute = m;
    cur_hour = h;
    mode_24h = m24;
  endtask

  // One-cycle carry into the day counter; day code meaning is ours to pick
  task next_day();
    @(posedge core_clk);
    #1;
    day_carry = 1'b1;
    @(posedge core_clk);
    #1;
    day_carry = 1'b0;
  endtask
endmodule // time_source

/* tb/tb.sv */
`timescale 1ns/100ps
`include "alarm_cfg.svh"
module tb;
  import alarm_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  reg_addr_t reg_addr = 4'h0;
  reg_data_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic osc_stop_flag = 1'b0;
  reg_data_t reg_rdata, d, v;
  bcd_minute_t cur_minute;
  bcd_hour_t cur_hour;
  logic mode_24h, day_carry, weekly_match, daily_match, weekly_pm, daily_pm_flag;
  weekday_t weekday;
  reg_addr_t a;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] seed = 8'h20;

  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  alarm_regs u_alarm_regs (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cur_minute(cur_minute), .cur_hour(cur_hour), .mode_24h(mode_24h),
    .day_carry(day_carry), .osc_stop_flag(osc_stop_flag), .weekday(weekday),
    .weekly_match(weekly_match), .daily_match(daily_match), .weekly_pm(weekly_pm),
    .daily_pm_flag(daily_pm_flag));
  time_source u_time_source (.core_clk(core_clk), .cur_minute(cur_minute),
    .cur_hour(cur_hour), .mode_24h(mode_24h), .day_carry(day_carry));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Bits kept by each alarm register; unused bits must read zero
  function automatic reg_data_t keep_mask(input reg_addr_t r);
    case (r)
      `ADDR_WEEKLY_HOUR, `ADDR_DAILY_HOUR: return 8'h3f;
      `ADDR_WEEKLY_MINUTE, `ADDR_DAILY_MINUTE, `ADDR_WEEKLY_DAY_MASK: return 8'h7f;
      default: return 8'h00;
    endcase
  endfunction

  task check(input reg_data_t got, input reg_data_t exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input reg_addr_t r, input reg_data_t x);
    @(posedge core_clk);
    #1;
    reg_addr = r;
    reg_wdata = x;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  // Data is picked up one edge after the taking edge, it holds till the next read
  task rd(input reg_addr_t r, output reg_data_t x);
    @(posedge core_clk);
    #1;
    reg_addr = r;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge core_clk);
    #1;
    x = reg_rdata;
  endtask

  // Write, then read the same address at the very next edge
  task wr_rd(input reg_addr_t r, input reg_data_t x, output reg_data_t y);
    @(posedge core_clk);
    #1;
    reg_addr = r;
    reg_wdata = x;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    y = reg_rdata;
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #40000;
    bad_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    rst = 1'b0;
    rd(`ADDR_DAILY_HOUR, d);
    check(d & 8'hc0, 8'h00);
    // All-ones first to hit the dropped bits, then random bytes
    for (int i = 0; i < 20; i++) begin
      a = 4'h8 + 4'(i % 5);
      seed = lfsr_next(seed);
      v = (i < 5) ? 8'hff : seed;
      wr_rd(a, v, d);
      check(d, v & keep_mask(a));
    end
    wr(4'h0, 8'hff);
    rd(4'h0, d);
    check(d, 8'h00);
    // Noon in 12-hour coding on both alarms
    wr(`ADDR_DAILY_MINUTE, 8'h59);
    wr(`ADDR_DAILY_HOUR, 8'h32);
    wr(`ADDR_WEEKLY_HOUR, 8'h32);
    u_time_source.set_time(7'h59, 6'h32, 1'b0);
    tick(2);
    check({7'h0, daily_match}, 8'h01);
    check({6'h0, weekly_pm, daily_pm_flag}, 8'h03);
    // 23:59 in 24-hour mode: bit 5 set, yet no afternoon flag
    wr(`ADDR_DAILY_HOUR, 8'h23);
    wr(`ADDR_WEEKLY_HOUR, 8'h23);
    u_time_source.set_time(7'h59, 6'h23, 1'b1);
    tick(2);
    check({6'h0, weekly_pm, daily_pm_flag}, 8'h00);
    check({7'h0, daily_match}, 8'h01);
    osc_stop_flag = 1'b1;
    tick(2);
    check({7'h0, daily_match}, 8'h00);
    osc_stop_flag = 1'b0;
    u_time_source.set_time(7'h58, 6'h23, 1'b1);
    tick(2);
    check({7'h0, daily_match}, 8'h00);
    // Weekly alarm, one day bit at a time, then an empty mask
    wr(`ADDR_WEEKLY_MINUTE, 8'h30);
    wr(`ADDR_WEEKLY_HOUR, 8'h12);
    u_time_source.set_time(7'h30, 6'h12, 1'b0);
    // Day counter keeps three bits only
    wr(`ADDR_WEEKDAY, 8'hfd);
    rd(`ADDR_WEEKDAY, d);
    check(d, 8'h05);
    wr(`ADDR_WEEKDAY, 8'h00);
    for (int n = 0; n < 8; n++) begin
      wr(`ADDR_WEEKLY_DAY_MASK, (n < 7) ? (8'h01 << n) : 8'h00);
      for (int k = 0; k < 7; k++) begin
        tick(2);
        check({5'h0, weekday}, 8'(k));
        check({7'h0, weekly_match}, 8'(n == k));
        u_time_source.next_day();
      end
    end
    tally_and_finish();
  end
endmodule // tb
